// *** pkg/idb_pkg.sv ***
// Package for the destination broadcaster: register map, frame layout, timing
package idb_pkg;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_L1_PACK   = 8'h04;
  localparam logic [7:0] ADDR_SL_PACK   = 8'h08;
  localparam logic [7:0] ADDR_L1_FDLY   = 8'h0C;
  localparam logic [7:0] ADDR_SL_FDLY   = 8'h10;
  localparam logic [7:0] ADDR_TBL_DEPTH = 8'h14;
  localparam logic [7:0] ADDR_TBL_ADDR  = 8'h18;
  localparam logic [7:0] ADDR_TBL_DATA  = 8'h1C;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_STOP_BIT   = 1;

  // Destination index and table size
  localparam int DEST_W    = 10;
  localparam int TBL_DEPTH = 1024;
  localparam int CNT_W     = 16;
  localparam int DLY_W     = 32;

  // Long broadcast frame layout
  localparam int FRAME_W       = 16;
  localparam int FR_TYPE_HI    = 15;
  localparam int FR_TYPE_LO    = 14;
  localparam logic [1:0] FR_TYPE_DEST = 2'h2;
  localparam int FR_CHAN_BIT   = 13;
  localparam int FR_FLUSH_BIT  = 12;

  // Channel identifiers carried in bit 13
  localparam logic CHAN_FIRST  = 1'b0;
  localparam logic CHAN_SECOND = 1'b1;

  // Reset values
  localparam logic [CNT_W-1:0]  RST_L1_PACK = 16'h0003;
  localparam logic [CNT_W-1:0]  RST_SL_PACK = 16'h0001;
  localparam logic [DLY_W-1:0]  RST_L1_FDLY = 32'h0000_1000;
  localparam logic [DLY_W-1:0]  RST_SL_FDLY = 32'h0000_2000;
  localparam logic [DEST_W:0]   RST_DEPTH   = 11'h001;

  // Broadcast channel occupancy
  localparam int CLK_NS        = 10;
  localparam int LONG_BCAST_NS = 1050;
  localparam int SHORT_BCAST_NS = 400;
  localparam int LONG_BCAST_CYC = (LONG_BCAST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] LONG_BCAST_CNT = LONG_BCAST_CYC[7:0];

endpackage

// *** hw/idb_broadcaster.sv ***
// Destination broadcaster: two channel machines, lookup table and long frame sender
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module idb_broadcaster
  import idb_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                l0_accept,
  input  wire logic                l1_accept,
  output logic                     l0_inhibit,
  output logic                     bcast_req,
  output logic      [FRAME_W-1:0]  bcast_frame,
  input  wire logic                bcast_ack
);

  typedef enum logic [1:0] {IDB_IDLE, IDB_SEND, IDB_HOLD} idb_state_type;

  logic [DEST_W-1:0] table_mem [TBL_DEPTH];

  logic              enable_ff,    nxt_enable;
  logic              stop_ff,      nxt_stop;
  logic [CNT_W-1:0]  l1_pack_ff,   nxt_l1_pack;
  logic [CNT_W-1:0]  sl_pack_ff,   nxt_sl_pack;
  logic [DLY_W-1:0]  l1_fdly_ff,   nxt_l1_fdly;
  logic [DLY_W-1:0]  sl_fdly_ff,   nxt_sl_fdly;
  logic [DEST_W:0]   depth_ff,     nxt_depth;
  logic [DEST_W-1:0] tbl_addr_ff,  nxt_tbl_addr;
  logic [31:0]       prdata_ff,    nxt_prdata;
  logic              pready_ff,    nxt_pready;
  logic              pslverr_ff,   nxt_pslverr;
  logic              inhibit_ff,   nxt_inhibit;
  logic [CNT_W-1:0]  cnt_ff [2];
  logic [CNT_W-1:0]  nxt_cnt [2];
  logic              pend_ff [2];
  logic              nxt_pend [2];
  logic              fpend_ff [2];
  logic              nxt_fpend [2];
  logic              fdone_ff [2];
  logic              nxt_fdone [2];
  logic [DLY_W-1:0]  fcnt_ff [2];
  logic [DLY_W-1:0]  nxt_fcnt [2];
  logic [DEST_W-1:0] rr_ff,        nxt_rr;
  idb_state_type     state_ff,     nxt_state;
  logic [7:0]        busy_ff,      nxt_busy;
  logic              req_ff,       nxt_req;
  logic [FRAME_W-1:0] frame_ff,    nxt_frame;
  logic              sel_ff,       nxt_sel;
  logic              selflush_ff,  nxt_selflush;

  logic wr_en;
  logic rd_en;
  logic tbl_we;
  logic bad_addr;
  logic acc [2];
  logic [CNT_W-1:0] pack [2];
  logic [DLY_W-1:0] fdly [2];

  // One wait state; write lands at the edge that shows pready
  assign wr_en  = psel && penable && pwrite && pready_ff;
  assign rd_en  = psel && !penable;
  assign tbl_we = wr_en && (paddr == ADDR_TBL_DATA);
  assign bad_addr = (paddr > ADDR_STATUS) || (paddr[1:0] != 2'h0);

  // first counts zero-level, second counts first-level accepts
  assign acc[0]  = l0_accept && enable_ff && !inhibit_ff;
  assign acc[1]  = l1_accept && enable_ff;
  assign pack[0] = l1_pack_ff;
  assign pack[1] = sl_pack_ff;
  assign fdly[0] = l1_fdly_ff;
  assign fdly[1] = sl_fdly_ff;

  always_comb begin
    nxt_enable   = enable_ff;
    nxt_stop     = stop_ff;
    nxt_l1_pack  = l1_pack_ff;
    nxt_sl_pack  = sl_pack_ff;
    nxt_l1_fdly  = l1_fdly_ff;
    nxt_sl_fdly  = sl_fdly_ff;
    nxt_depth    = depth_ff;
    nxt_tbl_addr = tbl_addr_ff;
    nxt_prdata   = prdata_ff;
    nxt_pready   = psel && penable && !pready_ff;
    nxt_pslverr  = psel && penable && !pready_ff && bad_addr;
    if (wr_en && !bad_addr) begin
      case (paddr)
        ADDR_CTRL: begin
          nxt_enable = pwdata[CTRL_ENABLE_BIT];
          nxt_stop   = pwdata[CTRL_STOP_BIT];
        end
        // interval below three clamped to three
        ADDR_L1_PACK:   nxt_l1_pack = (pwdata[CNT_W-1:0] < RST_L1_PACK) ? RST_L1_PACK : pwdata[CNT_W-1:0];
        ADDR_SL_PACK:   nxt_sl_pack = (pwdata[CNT_W-1:0] == '0) ? RST_SL_PACK : pwdata[CNT_W-1:0];
        ADDR_L1_FDLY:   nxt_l1_fdly = pwdata;
        ADDR_SL_FDLY:   nxt_sl_fdly = pwdata;
        // depth set to total processor count
        ADDR_TBL_DEPTH: nxt_depth = (pwdata[DEST_W:0] == '0) ? RST_DEPTH : pwdata[DEST_W:0];
        ADDR_TBL_ADDR:  nxt_tbl_addr = pwdata[DEST_W-1:0];
        ADDR_TBL_DATA:  nxt_tbl_addr = tbl_addr_ff + 10'h001;
        default: ;
      endcase
    end
    if (rd_en) begin
      case (paddr)
        ADDR_CTRL:      nxt_prdata = {30'h0, stop_ff, enable_ff};
        ADDR_L1_PACK:   nxt_prdata = {16'h0, l1_pack_ff};
        ADDR_SL_PACK:   nxt_prdata = {16'h0, sl_pack_ff};
        ADDR_L1_FDLY:   nxt_prdata = l1_fdly_ff;
        ADDR_SL_FDLY:   nxt_prdata = sl_fdly_ff;
        ADDR_TBL_DEPTH: nxt_prdata = {21'h0, depth_ff};
        ADDR_TBL_ADDR:  nxt_prdata = {22'h0, tbl_addr_ff};
        ADDR_TBL_DATA:  nxt_prdata = {22'h0, table_mem[tbl_addr_ff]};
        ADDR_STATUS:    nxt_prdata = {14'h0, rr_ff, fdone_ff[1], fdone_ff[0], fpend_ff[1], fpend_ff[0],
                                      pend_ff[1], pend_ff[0], inhibit_ff, req_ff};
        default:        nxt_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (tbl_we) begin
      table_mem[tbl_addr_ff] <= pwdata[DEST_W-1:0];
    end
  end

  // Per-channel counting, request and flush timing
  always_comb begin
    nxt_inhibit = inhibit_ff || stop_ff;
    for (int c = 0; c < 2; c++) begin
      nxt_cnt[c]   = cnt_ff[c];
      nxt_pend[c]  = pend_ff[c];
      nxt_fpend[c] = fpend_ff[c];
      nxt_fdone[c] = fdone_ff[c];
      nxt_fcnt[c]  = fcnt_ff[c];
      if (acc[c]) begin
        if (cnt_ff[c] + 16'h0001 >= pack[c]) begin
          nxt_cnt[c]  = '0;
          nxt_pend[c] = 1'b1;
        end else begin
          nxt_cnt[c] = cnt_ff[c] + 16'h0001;
        end
      end
      // flush delay restarts at each zero-level accept
      if (acc[0]) begin
        nxt_fcnt[c]  = '0;
        nxt_fdone[c] = 1'b0;
      end else if (inhibit_ff && !fdone_ff[c] && !fpend_ff[c]) begin
        // each channel counts its own delay
        if (fcnt_ff[c] >= fdly[c]) begin
          nxt_fpend[c] = 1'b1;
        end else begin
          nxt_fcnt[c] = fcnt_ff[c] + 32'h0000_0001;
        end
      end
    end
    if (state_ff == IDB_SEND && bcast_ack) begin
      if (selflush_ff) begin
        nxt_fpend[sel_ff] = 1'b0;
        nxt_fdone[sel_ff] = 1'b1;
        nxt_cnt[sel_ff]   = '0;
      end else if (!(acc[sel_ff] && cnt_ff[sel_ff] + 16'h0001 >= pack[sel_ff])) begin
        nxt_pend[sel_ff] = 1'b0;
      end
    end
  end

  // Shared long-frame sender; first channel has priority
  always_comb begin
    nxt_state    = state_ff;
    nxt_busy     = busy_ff;
    nxt_req      = req_ff;
    nxt_frame    = frame_ff;
    nxt_sel      = sel_ff;
    nxt_selflush = selflush_ff;
    nxt_rr       = rr_ff;
    case (state_ff)
      IDB_IDLE: begin
        if (fpend_ff[0] || pend_ff[0] || fpend_ff[1] || pend_ff[1]) begin
          nxt_sel      = (fpend_ff[0] || pend_ff[0]) ? CHAN_FIRST : CHAN_SECOND;
          nxt_selflush = (fpend_ff[0] || pend_ff[0]) ? fpend_ff[0] : fpend_ff[1];
          nxt_frame[FR_TYPE_HI:FR_TYPE_LO] = FR_TYPE_DEST;
          nxt_frame[11:10]                 = 2'h0;
          nxt_frame[FR_CHAN_BIT]  = nxt_sel;
          nxt_frame[FR_FLUSH_BIT] = nxt_selflush;
          nxt_frame[DEST_W-1:0]   = table_mem[rr_ff];
          nxt_req   = 1'b1;
          nxt_state = IDB_SEND;
        end
      end
      IDB_SEND: begin
        if (bcast_ack) begin
          nxt_req = 1'b0;
          if (!selflush_ff) begin
            nxt_rr = ({1'b0, rr_ff} + 11'h001 >= depth_ff) ? '0 : rr_ff + 10'h001;
          end
          nxt_busy  = LONG_BCAST_CNT;
          nxt_state = IDB_HOLD;
        end
      end
      IDB_HOLD: begin
        // channel occupied for a long frame
        if (busy_ff <= 8'h01) begin
          nxt_busy  = 8'h00;
          nxt_state = IDB_IDLE;
        end else begin
          nxt_busy = busy_ff - 8'h01;
        end
      end
      default: nxt_state = IDB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_ff   <= 1'b0;
      stop_ff     <= 1'b0;
      l1_pack_ff  <= RST_L1_PACK;
      sl_pack_ff  <= RST_SL_PACK;
      l1_fdly_ff  <= RST_L1_FDLY;
      sl_fdly_ff  <= RST_SL_FDLY;
      depth_ff    <= RST_DEPTH;
      tbl_addr_ff <= '0;
      prdata_ff   <= '0;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      inhibit_ff  <= 1'b0;
      rr_ff       <= '0;
      state_ff    <= IDB_IDLE;
      busy_ff     <= '0;
      req_ff      <= 1'b0;
      frame_ff    <= '0;
      sel_ff      <= CHAN_FIRST;
      selflush_ff <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        cnt_ff[c]   <= '0;
        pend_ff[c]  <= 1'b0;
        fpend_ff[c] <= 1'b0;
        fdone_ff[c] <= 1'b0;
        fcnt_ff[c]  <= '0;
      end
    end else begin
      enable_ff   <= nxt_enable;
      stop_ff     <= nxt_stop;
      l1_pack_ff  <= nxt_l1_pack;
      sl_pack_ff  <= nxt_sl_pack;
      l1_fdly_ff  <= nxt_l1_fdly;
      sl_fdly_ff  <= nxt_sl_fdly;
      depth_ff    <= nxt_depth;
      tbl_addr_ff <= nxt_tbl_addr;
      prdata_ff   <= nxt_prdata;
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
      inhibit_ff  <= nxt_inhibit;
      rr_ff       <= nxt_rr;
      state_ff    <= nxt_state;
      busy_ff     <= nxt_busy;
      req_ff      <= nxt_req;
      frame_ff    <= nxt_frame;
      sel_ff      <= nxt_sel;
      selflush_ff <= nxt_selflush;
      for (int c = 0; c < 2; c++) begin
        cnt_ff[c]   <= nxt_cnt[c];
        pend_ff[c]  <= nxt_pend[c];
        fpend_ff[c] <= nxt_fpend[c];
        fdone_ff[c] <= nxt_fdone[c];
        fcnt_ff[c]  <= nxt_fcnt[c];
      end
    end
  end

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign l0_inhibit  = inhibit_ff;
  assign bcast_req   = req_ff;
  assign bcast_frame = frame_ff;

endmodule

// *** tb/idb_broadcaster_properties.sv ***
// Port checker for the destination broadcaster
`timescale 1ns/10ps
module idb_props
  import idb_pkg::*;
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               l0_accept,
  input wire logic               l1_accept,
  input wire logic               l0_inhibit,
  input wire logic               bcast_req,
  input wire logic [FRAME_W-1:0] bcast_frame,
  input wire logic               bcast_ack
);
  logic [7:0] gap_ff;
  logic [7:0] nxt_gap;
  logic       f1_ff;
  logic       nxt_f1;
  wire        take = bcast_req && bcast_ack;
  wire        fl1 = bcast_frame[12] && !bcast_frame[13];
  always_comb begin
    nxt_gap = (gap_ff == 8'hFF) ? gap_ff : gap_ff + 8'h01;
    if (take) nxt_gap = 8'h00;
    nxt_f1 = f1_ff || (take && fl1);
  end
  always_ff @(posedge clk) begin
    gap_ff <= reset ? 8'hFF : nxt_gap;
    f1_ff  <= reset ? 1'b0 : nxt_f1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after access");
  apb_err_a: assert property (pslverr |-> pready && !$past(pready))
    else $error("pslverr without fresh pready");
  frame_fields_a: assert property (bcast_req |-> bcast_frame[15:14] == FR_TYPE_DEST && !bcast_frame[11:10])
    else $error("bad frame fields");
  req_hold_a: assert property (bcast_req && !bcast_ack |=> bcast_req && $stable(bcast_frame))
    else $error("request dropped before ack");
  req_drop_a: assert property (take |=> !bcast_req)
    else $error("request kept after ack");
  frame_gap_a: assert property ($rose(bcast_req) |-> gap_ff >= 8'd100)
    else $error("frames too close");
  inhibit_kept_a: assert property (l0_inhibit |=> l0_inhibit)
    else $error("inhibit released");
  flush_inhibit_a: assert property (bcast_req && bcast_frame[12] |-> l0_inhibit)
    else $error("flush before inhibit");
  flush_order_a: assert property (bcast_req && bcast_frame[12] && bcast_frame[13] |-> f1_ff)
    else $error("second flush first");
  flush_once_a: assert property (bcast_req && fl1 |-> !f1_ff)
    else $error("first flush repeated");
endmodule

bind idb_broadcaster idb_props idb_props_i (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .l0_accept(l0_accept), .l1_accept(l1_accept), .l0_inhibit(l0_inhibit),
  .bcast_req(bcast_req), .bcast_frame(bcast_frame), .bcast_ack(bcast_ack)
);

// *** tb/idb_bcast_model.sv ***
// Channel-B sender model taking destination frames
`timescale 1ns/10ps
module idb_bcast_model
  import idb_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               bcast_req,
  input  wire logic [FRAME_W-1:0] bcast_frame,
  input  wire logic [7:0]         ack_dly,
  input  wire logic [1:0][37:0]   mac_base,
  input  wire logic [1:0][21:0]   ip_base,
  output logic                    bcast_ack,
  output logic      [1:0][47:0]   dest_mac,
  output logic      [1:0][31:0]   dest_ip,
  output logic      [1:0]         flushed
);
  logic       ch;
  logic [7:0] wait_ff;
  logic [7:0] nxt_wait;
  logic       nxt_ack;
  // Only long destination frames, one at a time
  always_comb begin
    nxt_wait = (bcast_req && !bcast_ack) ? wait_ff + 8'h01 : 8'h00;
    nxt_ack  = bcast_req && !bcast_ack && wait_ff >= ack_dly && bcast_frame[15:14] == FR_TYPE_DEST;
  end
  always_ff @(posedge clk) begin
    wait_ff   <= reset ? 8'h00 : nxt_wait;
    bcast_ack <= reset ? 1'b0 : nxt_ack;
  end
  assign ch = bcast_frame[FR_CHAN_BIT];
  // Per-channel stored bases joined with index
  always_ff @(posedge clk) begin
    if (reset) begin
      dest_mac <= '0;
      dest_ip  <= '0;
      flushed  <= '0;
    end else if (bcast_req && bcast_ack) begin
      if (bcast_frame[FR_FLUSH_BIT]) begin
        flushed[ch] <= 1'b1;
      end else begin
        dest_mac[ch] <= {mac_base[ch], bcast_frame[DEST_W-1:0]};
        dest_ip[ch]  <= {ip_base[ch], bcast_frame[DEST_W-1:0]};
      end
    end
  end
endmodule

// *** tb/test_idb_broadcaster.sv ***
// Register and broadcast tests for the destination broadcaster
`timescale 1ns/10ps
module test_idb_broadcaster
  import idb_pkg::*;
;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic               l0_accept = 1'b0;
  logic               l1_accept = 1'b0;
  logic [7:0]         ack_dly = 8'h03;
  logic [31:0]        prdata;
  logic               pready, pslverr, l0_inhibit, bcast_req, bcast_ack;
  logic [FRAME_W-1:0] bcast_frame;
  logic [FRAME_W-1:0] got[$];
  logic [1:0][37:0]   mac_base = {38'h0A_5500_0001, 38'h01_2345_6700};
  logic [1:0][21:0]   ip_base = {22'h2A_0C01, 22'h0B_1F00};
  logic [1:0][47:0]   dest_mac;
  logic [1:0][31:0]   dest_ip;
  logic [1:0]         flushed;
  // Node 0x001 twice: weighted share
  logic [9:0]         tbl[4] = '{10'h3A5, 10'h001, 10'h3FF, 10'h001};
  int                 err_count = 0;
  int                 samples_checked = 0;

  idb_broadcaster idb_broadcaster_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .l0_accept(l0_accept), .l1_accept(l1_accept), .l0_inhibit(l0_inhibit),
    .bcast_req(bcast_req), .bcast_frame(bcast_frame), .bcast_ack(bcast_ack));
  idb_bcast_model idb_bcast_model_i (.clk(clk), .reset(reset), .bcast_req(bcast_req),
    .bcast_frame(bcast_frame), .ack_dly(ack_dly), .mac_base(mac_base), .ip_base(ip_base),
    .bcast_ack(bcast_ack), .dest_mac(dest_mac), .dest_ip(dest_ip), .flushed(flushed));

  initial forever #5 clk = ~clk;
  always @(posedge clk) if (bcast_req === 1'b1 && bcast_ack === 1'b1) got.push_back(bcast_frame);

  task conclude();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk64(input logic [63:0] g, input logic [63:0] e);
    chk(g[63:32], e[63:32]);
    chk(g[31:0], e[31:0]);
  endtask
  // Holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No timeout here; pready ends this wait, else the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task pulse(input logic ch, input int n);
    repeat (n) begin
      @(posedge clk);
      if (ch) l1_accept <= 1'b1; else l0_accept <= 1'b1;
      @(posedge clk);
      l0_accept <= 1'b0; l1_accept <= 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  task wait_frames(input int k);
    int n;
    n = 0;
    while (got.size() < k && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (got.size() < k) err_count++;
  endtask
  // Flush frames: index not compared
  task chk_frame(input int k, input logic ch, input logic fl, input logic [9:0] idx);
    if (fl) chk({26'h0, got[k][15:10]}, {26'h0, FR_TYPE_DEST, ch, 1'b1, 2'h0});
    else chk({16'h0, got[k]}, {16'h0, FR_TYPE_DEST, ch, 1'b0, 2'h0, idx});
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_L1_PACK, 32'h3);
    rd(ADDR_SL_PACK, 32'h1);
    rd(ADDR_L1_FDLY, 32'h1000);
    rd(ADDR_SL_FDLY, 32'h2000);
    rd(ADDR_TBL_DEPTH, 32'h1);
    rd(8'h24, 32'h0, 1'b1);
    rd(8'h05, 32'h0, 1'b1);
    wr(ADDR_L1_PACK, 32'h1);
    rd(ADDR_L1_PACK, 32'h3);
    wr(ADDR_TBL_DEPTH, 32'h4);
    wr(ADDR_TBL_ADDR, 32'h0);
    for (int k = 0; k < 4; k++) wr(ADDR_TBL_DATA, {22'h0, tbl[k]});
    wr(ADDR_TBL_ADDR, 32'h0);
    rd(ADDR_TBL_DATA, {22'h0, tbl[0]});
    wr(ADDR_SL_PACK, 32'h2);
    wr(ADDR_L1_FDLY, 32'd20);
    wr(ADDR_SL_FDLY, 32'd60);
    wr(ADDR_CTRL, 32'h1);
    pulse(1'b0, 15);
    wait_frames(5);
    for (int k = 0; k < 5; k++) chk_frame(k, CHAN_FIRST, 1'b0, tbl[k % 4]);
    ack_dly <= 8'd40;
    pulse(1'b1, 4);
    wait_frames(7);
    chk_frame(5, CHAN_SECOND, 1'b0, tbl[1]);
    chk_frame(6, CHAN_SECOND, 1'b0, tbl[2]);
    wr(ADDR_CTRL, 32'h3);
    // Stop lands with pready, inhibit follows one edge later
    repeat (2) @(posedge clk);
    chk({31'h0, l0_inhibit}, 32'h1);
    wait_frames(9);
    chk_frame(7, CHAN_FIRST, 1'b1, 10'h0);
    chk_frame(8, CHAN_SECOND, 1'b1, 10'h0);
    repeat (300) @(posedge clk);
    chk(got.size(), 32'd9);
    rd(ADDR_STATUS, 32'h0000_03C2);
    chk64({16'h0, dest_mac[0]}, {16'h0, mac_base[0], tbl[0]});
    chk64({16'h0, dest_mac[1]}, {16'h0, mac_base[1], tbl[2]});
    chk(dest_ip[0], {ip_base[0], tbl[0]});
    chk(dest_ip[1], {ip_base[1], tbl[2]});
    chk({30'h0, flushed}, 32'h3);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule
